/* pkg/sre_defines.svh */
// constants for the receiver error handler
`ifndef SRE_DEFINES_SVH
`define SRE_DEFINES_SVH

// receiver status register bit positions
`define SRE_ST_PROF 0
`define SRE_ST_NPCM 1
`define SRE_ST_ABSENT 2
`define SRE_ST_VALID 3
`define SRE_ST_LOCK 4
`define SRE_ST_CRC 5
`define SRE_ST_PARITY 6
`define SRE_ST_CODING 7
`define SRE_STATUS_RST 8'h40

// sticky vector bit positions
`define SRE_SK_VALID 0
`define SRE_SK_NPCM 1
`define SRE_SK_ABSENT 2
`define SRE_SK_CODING 3
`define SRE_SK_PARITY 4
`define SRE_SK_LOCK 5
`define SRE_STICKY_RST 6'h00

// action field codes
`define SRE_ACT_FIELD_NONE 2'h0
`define SRE_ACT_FIELD_RSVD 2'h3

// timing
`define SRE_CLK_NS 5
`define SRE_ABSENT_NS 100000
`define SRE_ABSENT_CYC ((`SRE_ABSENT_NS + `SRE_CLK_NS - 1) / `SRE_CLK_NS)
`define SRE_FRAME_NS 20833
`define SRE_FRAME_CYC (`SRE_FRAME_NS / `SRE_CLK_NS)
`define SRE_MUTE_FRAMES 4096

// channel status block
`define SRE_CS_BITS 192
`define SRE_CS_CRC_START 184
`define SRE_CRC_INIT 8'hff
`define SRE_CRC_POLY 8'h1d

`endif

/* pkg/sre_pkg.sv */
// types for the receiver error handler
package sre_pkg;
   typedef enum logic [1:0] {
      SRE_ACT_NONE,
      SRE_ACT_HOLD,
      SRE_ACT_ZERO,
      SRE_ACT_MUTE
   } sre_action_t;

   typedef enum logic [1:0] {
      SRE_MUTE_RUN,
      SRE_MUTE_RAMP,
      SRE_MUTE_SILENT
   } sre_mute_state_t;
endpackage

/* logic/sre_chstat_check.sv */
// channel status block tracker: mode bits, crc check, change detect
`timescale 1ns/10ps
`default_nettype none
`include "sre_defines.svh"

module sre_chstat_check
   import sre_pkg::*;
#(
   parameter int CS_BITS = `SRE_CS_BITS,
   parameter int CRC_START = `SRE_CS_CRC_START
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic bit_stb,
   input wire logic cs_bit,
   input wire logic blk_start,
   output logic prof,
   output logic npcm,
   output logic crc_fail,
   output logic change
);

   logic [7:0] idx_ff, nxt_idx;
   logic [7:0] crc_ff, nxt_crc;
   logic [CS_BITS-1:0] prev_ff, nxt_prev;
   logic miss_ff, nxt_miss, diff_ff, nxt_diff, seen_ff, nxt_seen;
   logic prof_ff, nxt_prof, npcm_ff, nxt_npcm;
   logic fail_ff, nxt_fail, chg_ff, nxt_chg;

   always_comb begin
      logic [7:0] pos;
      logic [7:0] base;
      logic fb;
      pos = blk_start ? 8'h00 : 8'(idx_ff + 8'h01);
      base = (pos == 8'h00) ? `SRE_CRC_INIT : crc_ff;
      fb = base[7] ^ cs_bit;
      nxt_idx = idx_ff;
      nxt_crc = crc_ff;
      nxt_prev = prev_ff;
      nxt_miss = miss_ff;
      nxt_diff = diff_ff;
      nxt_seen = seen_ff;
      nxt_prof = prof_ff;
      nxt_npcm = npcm_ff;
      nxt_fail = fail_ff;
      nxt_chg = 1'b0;
      if (bit_stb && (blk_start || int'(idx_ff) < CS_BITS - 1)) begin
         nxt_idx = pos;
         if (pos == 8'h00) begin
            nxt_miss = 1'b0;
            nxt_diff = 1'b0;
            nxt_prof = cs_bit;
            nxt_fail = fail_ff & cs_bit;
         end
         if (pos == 8'h01) begin
            nxt_npcm = cs_bit;
         end
         if (int'(pos) < CRC_START) begin
            nxt_crc = {base[6:0], 1'b0} ^ (fb ? `SRE_CRC_POLY : 8'h00);
         end else if (cs_bit != crc_ff[3'(CS_BITS - 1 - int'(pos))]) begin
            nxt_miss = 1'b1;
         end
         if (seen_ff && cs_bit != prev_ff[pos]) begin
            nxt_diff = 1'b1;
         end
         nxt_prev[pos] = cs_bit;
         if (int'(pos) == CS_BITS - 1) begin
            // crc only judged in professional mode
            nxt_fail = nxt_prof & nxt_miss;
            nxt_chg = nxt_diff;
            nxt_seen = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         idx_ff <= 8'hff;
         crc_ff <= `SRE_CRC_INIT;
         prev_ff <= '0;
         miss_ff <= 1'b0;
         diff_ff <= 1'b0;
         seen_ff <= 1'b0;
         prof_ff <= 1'b0;
         npcm_ff <= 1'b0;
         fail_ff <= 1'b0;
         chg_ff <= 1'b0;
      end else begin
         idx_ff <= nxt_idx;
         crc_ff <= nxt_crc;
         prev_ff <= nxt_prev;
         miss_ff <= nxt_miss;
         diff_ff <= nxt_diff;
         seen_ff <= nxt_seen;
         prof_ff <= nxt_prof;
         npcm_ff <= nxt_npcm;
         fail_ff <= nxt_fail;
         chg_ff <= nxt_chg;
      end
   end

   assign prof = prof_ff;
   assign npcm = npcm_ff;
   assign crc_fail = fail_ff;
   assign change = chg_ff;

endmodule

`default_nettype wire

/* logic/sre_error_handler.sv */
// error handling and sample treatment for the biphase audio receiver
//
// Notes on behaviour
// - lock flag bit 4 tracks pll lock
// - bit 7 set on biphase coding violation
// - bit 6 high for even parity, low odd
// - crc checked only in professional mode
// - stream absent flag when stream disconnected
// - absent with pcm: linear ramp over 4096 frames
// - charge pump high impedance during ramp
// - absent with non-pcm: send zeros
// - unlock action: none, hold, zero, mute
// - non-pcm content forces unlock action zero
// - line error action: none, hold, zero
// - sticky copies of six status indications
// - lock, validity, absent, non-pcm interrupt sources
// - parity or biphase error gives line irq
// - interrupt on channel status change
// - biphase and validity irqs one-cycle pulses
// - byte 0 bit 1 selects pcm/non-pcm
`timescale 1ns/10ps
`default_nettype none
`include "sre_defines.svh"

module sre_error_handler
   import sre_pkg::*;
#(
   parameter int SAMPLE_W = 24,
   parameter int ABSENT_CYC = `SRE_ABSENT_CYC,
   parameter int FRAME_CYC = `SRE_FRAME_CYC,
   parameter int MUTE_FRAMES = `SRE_MUTE_FRAMES
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic frame_clk,
   input wire logic pll_lock_pin,
   input wire logic coding_viol_pin,
   input wire logic parity_even_pin,
   input wire logic validity_pin,
   input wire logic cs_bit_pin,
   input wire logic block_start_pin,
   input wire logic [SAMPLE_W-1:0] sample_pin,
   input wire logic [1:0] unlock_action_field,
   input wire logic [1:0] line_error_action_field,
   input wire logic sticky_clr,
   output logic [SAMPLE_W-1:0] audio_out,
   output logic audio_stb,
   output logic cp_hiz,
   output logic [7:0] receiver_status_reg,
   output logic [5:0] sticky,
   output logic irq_lock,
   output logic irq_validity,
   output logic irq_absent,
   output logic irq_non_pcm,
   output logic irq_line_err,
   output logic irq_chstat_change
);

   localparam int LW = SAMPLE_W + 7;
   localparam int CW = 24;
   localparam int MW = $clog2(MUTE_FRAMES + 1);
   localparam int MSH = $clog2(MUTE_FRAMES);

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers and frame edge

   logic [LW-1:0] sync1_ff, nxt_sync1, sync2_ff, nxt_sync2;
   logic frame_prev_ff, nxt_frame_prev;
   logic s_frame, s_lock, s_coding, s_parity, s_valid, s_csbit, s_blk;
   logic [SAMPLE_W-1:0] s_sample;
   logic frame_edge;

   always_comb begin
      nxt_sync1 = {frame_clk, pll_lock_pin, coding_viol_pin,
         parity_even_pin, validity_pin, cs_bit_pin, block_start_pin,
         sample_pin};
      nxt_sync2 = sync1_ff;
      nxt_frame_prev = s_frame;
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
         frame_prev_ff <= 1'b0;
      end else begin
         sync1_ff <= nxt_sync1;
         sync2_ff <= nxt_sync2;
         frame_prev_ff <= nxt_frame_prev;
      end
   end

   assign {s_frame, s_lock, s_coding, s_parity, s_valid, s_csbit, s_blk,
      s_sample} = sync2_ff;
   assign frame_edge = s_frame & ~frame_prev_ff;

   ////////////////////////////////////////////////////////////////////
   // stream absence and local frame timing

   logic [CW-1:0] gap_ff, nxt_gap, ftmr_ff, nxt_ftmr;
   logic absent_ff, nxt_absent;
   logic itick, tick;

   always_comb begin
      nxt_gap = gap_ff;
      if (frame_edge) begin
         nxt_gap = '0;
      end else if (gap_ff < CW'(ABSENT_CYC)) begin
         nxt_gap = CW'(gap_ff + 1'b1);
      end
      // no frame edge for the timeout means the stream is gone
      nxt_absent = ~frame_edge & (gap_ff >= CW'(ABSENT_CYC - 1));
      itick = absent_ff & (ftmr_ff == CW'(FRAME_CYC - 1));
      nxt_ftmr = (absent_ff && !itick) ? CW'(ftmr_ff + 1'b1) : '0;
   end

   assign tick = frame_edge | itick;

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         gap_ff <= '0;
         ftmr_ff <= '0;
         absent_ff <= 1'b0;
      end else begin
         gap_ff <= nxt_gap;
         ftmr_ff <= nxt_ftmr;
         absent_ff <= nxt_absent;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // channel status tracking

   logic cs_prof, cs_npcm, cs_crc_fail, cs_change;

   sre_chstat_check u_chstat (
      .core_clk(core_clk),
      .nrst(nrst),
      .bit_stb(frame_edge),
      .cs_bit(s_csbit),
      .blk_start(s_blk),
      .prof(cs_prof),
      .npcm(cs_npcm),
      .crc_fail(cs_crc_fail),
      .change(cs_change)
   );

   ////////////////////////////////////////////////////////////////////
   // live status, sticky copies, interrupt pulses

   logic [7:0] status_ff, nxt_status;
   logic [5:0] sticky_ff, nxt_sticky, sticky_set;
   logic irq_valid_ff, nxt_irq_valid, irq_line_ff, nxt_irq_line;
   logic line_err_now;

   assign line_err_now = s_coding | ~s_parity;

   always_comb begin
      nxt_status = status_ff;
      nxt_status[`SRE_ST_LOCK] = s_lock;
      nxt_status[`SRE_ST_ABSENT] = absent_ff;
      nxt_status[`SRE_ST_CRC] = cs_crc_fail;
      nxt_status[`SRE_ST_PROF] = cs_prof;
      nxt_status[`SRE_ST_NPCM] = cs_npcm;
      if (frame_edge) begin
         nxt_status[`SRE_ST_CODING] = s_coding;
         nxt_status[`SRE_ST_PARITY] = s_parity;
         nxt_status[`SRE_ST_VALID] = s_valid;
      end
      sticky_set = '0;
      sticky_set[`SRE_SK_VALID] = status_ff[`SRE_ST_VALID];
      sticky_set[`SRE_SK_NPCM] = status_ff[`SRE_ST_NPCM];
      sticky_set[`SRE_SK_ABSENT] = status_ff[`SRE_ST_ABSENT];
      sticky_set[`SRE_SK_CODING] = status_ff[`SRE_ST_CODING];
      sticky_set[`SRE_SK_PARITY] = ~status_ff[`SRE_ST_PARITY];
      sticky_set[`SRE_SK_LOCK] = status_ff[`SRE_ST_LOCK];
      // a set in the clearing cycle survives
      nxt_sticky = (sticky_clr ? '0 : sticky_ff) | sticky_set;
      nxt_irq_valid = frame_edge & s_valid;
      nxt_irq_line = frame_edge & line_err_now;
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         status_ff <= `SRE_STATUS_RST;
         sticky_ff <= `SRE_STICKY_RST;
         irq_valid_ff <= 1'b0;
         irq_line_ff <= 1'b0;
      end else begin
         status_ff <= nxt_status;
         sticky_ff <= nxt_sticky;
         irq_valid_ff <= nxt_irq_valid;
         irq_line_ff <= nxt_irq_line;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // sample treatment and soft mute

   sre_action_t act;
   sre_mute_state_t mute_st_ff, nxt_mute_st;
   logic [SAMPLE_W-1:0] last_ff, nxt_last, val_ff, nxt_val;
   logic [SAMPLE_W-1:0] step_ff, nxt_step, out_ff, nxt_out;
   logic [MW-1:0] cnt_ff, nxt_cnt;
   logic stb_ff, nxt_stb, hiz_ff, nxt_hiz;
   logic npcm_now, lock_now;

   assign npcm_now = status_ff[`SRE_ST_NPCM];
   assign lock_now = status_ff[`SRE_ST_LOCK];

   always_comb begin
      if (absent_ff) begin
         act = npcm_now ? SRE_ACT_ZERO : SRE_ACT_MUTE;
      end else if (!lock_now) begin
         if (npcm_now) begin
            act = SRE_ACT_ZERO;
         end else begin
            act = sre_action_t'(unlock_action_field);
         end
      end else if (line_err_now) begin
         if (line_error_action_field == `SRE_ACT_FIELD_RSVD) begin
            act = SRE_ACT_NONE;
         end else begin
            act = sre_action_t'(line_error_action_field);
         end
      end else begin
         act = SRE_ACT_NONE;
      end
   end

   always_comb begin
      nxt_mute_st = mute_st_ff;
      nxt_val = val_ff;
      nxt_step = step_ff;
      nxt_cnt = cnt_ff;
      nxt_last = last_ff;
      nxt_out = out_ff;
      nxt_stb = 1'b0;
      if (frame_edge && !absent_ff && lock_now && !line_err_now) begin
         nxt_last = s_sample;
      end
      if (tick) begin
         nxt_stb = 1'b1;
         if (act == SRE_ACT_MUTE) begin
            case (mute_st_ff)
               SRE_MUTE_RUN: begin
                  nxt_step = SAMPLE_W'($signed(last_ff) >>> MSH);
                  nxt_val = SAMPLE_W'(last_ff - nxt_step);
                  nxt_cnt = MW'(MUTE_FRAMES - 1);
                  nxt_mute_st = SRE_MUTE_RAMP;
               end
               SRE_MUTE_RAMP: begin
                  if (cnt_ff == MW'(1)) begin
                     nxt_val = '0;
                     nxt_cnt = '0;
                     nxt_mute_st = SRE_MUTE_SILENT;
                  end else begin
                     nxt_val = SAMPLE_W'(val_ff - step_ff);
                     nxt_cnt = MW'(cnt_ff - 1'b1);
                  end
               end
               SRE_MUTE_SILENT: begin
                  nxt_val = '0;
               end
               default: begin
                  nxt_mute_st = SRE_MUTE_RUN;
               end
            endcase
         end else begin
            nxt_mute_st = SRE_MUTE_RUN;
            nxt_cnt = '0;
         end
         case (act)
            SRE_ACT_NONE: nxt_out = s_sample;
            SRE_ACT_HOLD: nxt_out = last_ff;
            SRE_ACT_ZERO: nxt_out = '0;
            SRE_ACT_MUTE: nxt_out = nxt_val;
            default: nxt_out = '0;
         endcase
      end
      nxt_hiz = (nxt_mute_st == SRE_MUTE_RAMP);
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         mute_st_ff <= SRE_MUTE_RUN;
         val_ff <= '0;
         step_ff <= '0;
         cnt_ff <= '0;
         last_ff <= '0;
         out_ff <= '0;
         stb_ff <= 1'b0;
         hiz_ff <= 1'b0;
      end else begin
         mute_st_ff <= nxt_mute_st;
         val_ff <= nxt_val;
         step_ff <= nxt_step;
         cnt_ff <= nxt_cnt;
         last_ff <= nxt_last;
         out_ff <= nxt_out;
         stb_ff <= nxt_stb;
         hiz_ff <= nxt_hiz;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs

   assign audio_out = out_ff;
   assign audio_stb = stb_ff;
   assign cp_hiz = hiz_ff;
   assign receiver_status_reg = status_ff;
   assign sticky = sticky_ff;
   assign irq_lock = status_ff[`SRE_ST_LOCK];
   assign irq_validity = irq_valid_ff;
   assign irq_absent = status_ff[`SRE_ST_ABSENT];
   assign irq_non_pcm = status_ff[`SRE_ST_NPCM];
   assign irq_line_err = irq_line_ff;
   assign irq_chstat_change = cs_change;

   ////////////////////////////////////////////////////////////////////
   // checks

   a_lock_flag: assert property (
      @(posedge core_clk) disable iff (!nrst)
      ##1 receiver_status_reg[`SRE_ST_LOCK] == $past(s_lock))
      else $error("lock flag does not follow pll lock");

   a_coding_flag: assert property (
      @(posedge core_clk) disable iff (!nrst)
      frame_edge && s_coding |=> receiver_status_reg[`SRE_ST_CODING])
      else $error("coding fault flag not set");

   a_parity_flag: assert property (
      @(posedge core_clk) disable iff (!nrst)
      frame_edge |=> receiver_status_reg[`SRE_ST_PARITY] == $past(s_parity))
      else $error("parity flag wrong sense");

   a_crc_gated: assert property (
      @(posedge core_clk) disable iff (!nrst)
      receiver_status_reg[`SRE_ST_CRC] |-> receiver_status_reg[`SRE_ST_PROF])
      else $error("crc failure outside professional mode");

   a_absent_clear: assert property (
      @(posedge core_clk) disable iff (!nrst)
      frame_edge |=> ##1 !irq_absent)
      else $error("absent flag stays after frame edge");

   a_ramp_end: assert property (
      @(posedge core_clk) disable iff (!nrst)
      tick && act == SRE_ACT_MUTE && mute_st_ff == SRE_MUTE_RAMP
      && cnt_ff == MW'(1) |=> audio_stb && audio_out == '0 && !cp_hiz)
      else $error("soft mute does not end at zero");

   a_hiz_ramp: assert property (
      @(posedge core_clk) disable iff (!nrst)
      cp_hiz |-> cnt_ff != '0 && mute_st_ff == SRE_MUTE_RAMP)
      else $error("charge pump released outside ramp");

   a_npcm_zero: assert property (
      @(posedge core_clk) disable iff (!nrst)
      tick && npcm_now && (absent_ff || !lock_now)
      |=> audio_stb && audio_out == '0)
      else $error("non-pcm loss did not send zeros");

   a_hold_last: assert property (
      @(posedge core_clk) disable iff (!nrst)
      tick && act == SRE_ACT_HOLD |=> audio_out == $past(last_ff))
      else $error("hold did not repeat last valid sample");

   a_sticky_set: assert property (
      @(posedge core_clk) disable iff (!nrst)
      $rose(irq_absent) |=> sticky[`SRE_SK_ABSENT])
      else $error("absent sticky not set");

   a_line_irq: assert property (
      @(posedge core_clk) disable iff (!nrst)
      frame_edge && (s_coding || !s_parity) |=> irq_line_err ##1 !irq_line_err)
      else $error("line error pulse missing or long");

   a_valid_pulse: assert property (
      @(posedge core_clk) disable iff (!nrst)
      irq_validity |=> !irq_validity)
      else $error("validity pulse longer than one cycle");

endmodule

`default_nettype wire

/* test/sre_stream_src.sv */
// stream source model: frame clock and per-frame pins
`timescale 1ns/10ps
`default_nettype none

module sre_stream_src (
   output logic frame_clk,
   output logic coding_viol_pin,
   output logic parity_even_pin,
   output logic validity_pin,
   output logic cs_bit_pin,
   output logic block_start_pin,
   output logic [23:0] sample_pin
);
   initial begin
      frame_clk = 1'b0;
      {coding_viol_pin, parity_even_pin, validity_pin} = 3'h2;
      {cs_bit_pin, block_start_pin} = 2'h0;
      sample_pin = 24'h0;
   end

   // one frame, f = {viol, parity ok, valid, cs bit, block start}
   task automatic send_frame(input logic [23:0] s, input logic [4:0] f);
      #1.3;
      {coding_viol_pin, parity_even_pin, validity_pin, cs_bit_pin,
         block_start_pin} = f;
      sample_pin = s;
      #40 frame_clk = 1'b1;
      #40 frame_clk = 1'b0;
      // released lines stop showing the frame data
      sample_pin = ~s;
      cs_bit_pin = ~cs_bit_pin;
   endtask
endmodule
`default_nettype wire

/* test/sre_error_handler_bench.sv */
// self-checking bench for the receiver error handler
`timescale 1ns/10ps
`default_nettype none

module sre_error_handler_bench;
   import sre_pkg::*;
   localparam logic [23:0] A = 24'h100000;
   localparam logic [23:0] B = 24'h0abcde;
   logic core_clk, nrst, lock, sticky_clr, fclk, viol, par, vld, csb, bst;
   logic [1:0] ua, la;
   logic [23:0] smp, aout;
   logic stb, cp_hiz, i_lock, i_vld, i_abs, i_npcm, i_line, i_chg;
   logic [7:0] st;
   logic [5:0] sk;
   logic [23:0] got[$];
   logic [191:0] blk;
   int err_count, compares, tick, vcyc, lcyc, ccyc, lkcyc;
   logic lk_q;

   sre_error_handler #(.SAMPLE_W(24), .ABSENT_CYC(40), .FRAME_CYC(8),
      .MUTE_FRAMES(16)) dut (.core_clk(core_clk), .nrst(nrst),
      .frame_clk(fclk), .pll_lock_pin(lock), .coding_viol_pin(viol),
      .parity_even_pin(par), .validity_pin(vld), .cs_bit_pin(csb),
      .block_start_pin(bst), .sample_pin(smp), .unlock_action_field(ua),
      .line_error_action_field(la), .sticky_clr(sticky_clr),
      .audio_out(aout), .audio_stb(stb), .cp_hiz(cp_hiz),
      .receiver_status_reg(st), .sticky(sk), .irq_lock(i_lock),
      .irq_validity(i_vld), .irq_absent(i_abs), .irq_non_pcm(i_npcm),
      .irq_line_err(i_line), .irq_chstat_change(i_chg));

   sre_stream_src src (.frame_clk(fclk), .coding_viol_pin(viol),
      .parity_even_pin(par), .validity_pin(vld), .cs_bit_pin(csb),
      .block_start_pin(bst), .sample_pin(smp));

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      if (stb === 1'b1) got.push_back(aout);
      vcyc += int'(i_vld === 1'b1);
      lcyc += int'(i_line === 1'b1);
      ccyc += int'(i_chg === 1'b1);
      lkcyc += int'(i_lock !== lk_q);
      lk_q = i_lock;
      tick++;
      if (tick == 40000) begin
         err_count++;
         test_done();
      end
   end

   task automatic test_done();
      if (err_count == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(input string what, input logic [23:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic setc(input logic lk, input logic [1:0] u, l);
      @(posedge core_clk);
      lock <= lk;
      ua <= u;
      la <= l;
   endtask

   task automatic wait_stb(input int n);
      for (int i = 0; i < 3000 && got.size() < n; i++) @(posedge core_clk);
   endtask

   task automatic send_block(input logic p, np, bad);
      logic [7:0] c;
      blk = '0;
      blk[0] = p;
      blk[1] = np;
      c = 8'hff;
      for (int i = 0; i < 184; i++)
         c = {c[6:0], 1'b0} ^ ((c[7] ^ blk[i]) ? 8'h1d : 8'h00);
      for (int i = 0; i < 8; i++) blk[184 + i] = c[7 - i] ^ bad;
      ccyc = 0;
      for (int i = 0; i < 192; i++)
         src.send_frame(A, {3'b010, blk[i], i == 0});
      repeat (4) @(posedge core_clk);
   endtask

   initial begin
      nrst = 1'b0;
      lock = 1'b0;
      sticky_clr = 1'b0;
      ua = 2'h0;
      la = 2'h0;
      {err_count, compares, tick, vcyc, lcyc, ccyc} = '0;
      repeat (16) @(posedge core_clk);
      check("status", 24'(st), 24'h40);
      check("sticky", 24'(sk), 24'h0);
      nrst <= 1'b1;
      setc(1'b1, 2'h0, 2'h0);
      repeat (6) @(posedge core_clk);
      check("lock", 24'(st[4]), 24'h1);
      check("lock irq", 24'(i_lock), 24'h1);
      got.delete();
      vcyc = 0;
      src.send_frame(B, 5'b01100);
      check("pass", got[$], B);
      check("valid pulse", 24'(vcyc), 24'h1);
      check("valid sticky", 24'(sk[0]), 24'h1);
      // line error actions for coding fault and odd parity
      for (int l = 0; l < 4; l++) begin
         for (int k = 0; k < 2; k++) begin
            setc(1'b1, 2'h0, 2'(l));
            src.send_frame(A, 5'b01000);
            @(posedge core_clk) sticky_clr <= 1'b1;
            @(posedge core_clk) sticky_clr <= 1'b0;
            lcyc = 0;
            src.send_frame(B, k ? 5'b00000 : 5'b11000);
            check("line out", got[$], l == 1 ? A : l == 2 ? 24'h0 : B);
            check("line irq", 24'(lcyc), 24'h1);
            check("coding", 24'(st[7]), 24'(k == 0));
            check("parity", 24'(st[6]), 24'(k == 0));
            check("err sticky", 24'(sk[4:3]), k ? 24'h2 : 24'h1);
         end
      end
      // unlock actions
      lkcyc = 0;
      for (int u = 0; u < 4; u++) begin
         setc(1'b1, 2'(u), 2'h0);
         repeat (6) @(posedge core_clk);
         src.send_frame(A, 5'b01000);
         setc(1'b0, 2'(u), 2'h0);
         repeat (6) @(posedge core_clk);
         check("unlocked", 24'(st[4]), 24'h0);
         src.send_frame(B, 5'b01000);
         check("unlock out", got[$], u == 0 ? B : u == 1 ? A :
            u == 2 ? 24'h0 : 24'h0f0000);
      end
      check("lock edges", 24'(lkcyc), 24'h7);
      check("ramp hiz", 24'(cp_hiz), 24'h1);
      for (int i = 0; i < 16; i++) src.send_frame(B, 5'b01000);
      check("ramp end", got[$], 24'h0);
      check("hiz off", 24'(cp_hiz), 24'h0);
      setc(1'b1, 2'h0, 2'h0);
      repeat (6) @(posedge core_clk);
      // channel status blocks
      send_block(1'b1, 1'b0, 1'b0);
      check("prof", 24'(st[0]), 24'h1);
      check("crc ok", 24'(st[5]), 24'h0);
      check("first chg", 24'(ccyc), 24'h0);
      send_block(1'b1, 1'b1, 1'b1);
      check("crc bad", 24'(st[5]), 24'h1);
      check("non pcm", 24'(st[1]), 24'h1);
      check("npcm irq", 24'(i_npcm), 24'h1);
      check("chg irq", 24'(ccyc), 24'h1);
      check("npcm sticky", 24'(sk[1]), 24'h1);
      setc(1'b0, 2'h1, 2'h0);
      repeat (6) @(posedge core_clk);
      src.send_frame(B, 5'b01000);
      check("npcm unlock", got[$], 24'h0);
      setc(1'b1, 2'h0, 2'h0);
      got.delete();
      wait_stb(4);
      for (int i = 0; i < 4; i++) check("npcm zero", got[i], 24'h0);
      check("absent", 24'(st[2]), 24'h1);
      check("absent irq", 24'(i_abs), 24'h1);
      check("absent sticky", 24'(sk[2]), 24'h1);
      check("npcm hiz", 24'(cp_hiz), 24'h0);
      send_block(1'b0, 1'b0, 1'b1);
      check("crc off", 24'(st[5]), 24'h0);
      check("pcm", 24'(st[1]), 24'h0);
      // absence during pcm ramps down
      src.send_frame(A, 5'b01000);
      got.delete();
      wait_stb(2);
      check("abs hiz", 24'(cp_hiz), 24'h1);
      wait_stb(20);
      for (int k = 1; k <= 20; k++)
         check("ramp", got[k - 1], k < 16 ? 24'(A - k * 24'h10000) : 24'h0);
      check("abs hiz off", 24'(cp_hiz), 24'h0);
      test_done();
   end
endmodule
`default_nettype wire
